// ===== common/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// Register byte offsets
`define ACS_OFF_CTRL     6'h00
`define ACS_OFF_CMD      6'h04
`define ACS_OFF_SEL      6'h08
`define ACS_OFF_SAMP     6'h0C
`define ACS_OFF_FLAGS    6'h10
`define ACS_OFF_RESULT   6'h14
`define ACS_OFF_ACTIVE   6'h18
// CTRL fields
`define ACS_CTRL_EN      0
`define ACS_CTRL_CONT    1
`define ACS_CTRL_RES     2
`define ACS_CTRL_EVST    3
`define ACS_CTRL_PRE_LO  4
`define ACS_CTRL_PRE_HI  6
`define ACS_CTRL_RRIE    7
// Command and flag bits
`define ACS_CMD_GO       0
`define ACS_FLAG_RR      0
// SEL fields
`define ACS_SEL_CH_HI    4
`define ACS_SEL_REF_LO   8
`define ACS_SEL_REF_HI   9
// SAMP fields
`define ACS_SAMP_DLY_HI  3
`define ACS_SAMP_LEN_LO  8
`define ACS_SAMP_LEN_HI  11
`define ACS_SAMP_ACC_LO  16
`define ACS_SAMP_ACC_HI  18
// Timing in converter clock cycles, accumulation limit and widths
`define ACS_CONV_BASE    6'h0D
`define ACS_SAMP_BASE    6'h02
`define ACS_ACC_MAX      3'h6
`define ACS_DATA_W       10
`define ACS_RES_W        16
`endif

// ===== common/acs_pkg.sv
package acs_pkg;
  // Sequencer phase
  typedef enum logic {
    ACS_IDLE,
    ACS_CONV
  } acs_state_t;
endpackage

// ===== verilog/acs_sequencer.sv
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "acs_map.svh"
// Notes on behaviour
// - Start bit begins conversion, reads busy
// - Channel change waits for running conversion
// - Finished operation sets the ready flag
// - Interrupt needs flag, enable, global enable
// - Flag sets even with interrupt disabled
// - Event rising edge sets start bit
// - Continuous mode restarts after each completion
// - Converter clock divided by selectable ratio
// - Divider runs only while enabled
// - Divider reset when idle, fixed start delay
// - Conversion lasts thirteen plus delay plus length cycles
// - Sample instant two plus delay plus length cycles after start
// - Flag cleared by result read or write-one
// - Sampling lasts two plus delay plus length
// - Continuous period thirteen plus delay plus length
// - Selections buffered, copied until conversion starts
// - Disabled block ignores selections, draws no power
// - Result right-aligned ten bits
// - Accumulate up to 64 samples per trigger
// - Copying resumes in final converter cycle
// - One-cycle result event while enabled
module acs_sequencer (
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // System side
  input  wire logic               global_irq_enable,
  input  wire logic               start_event,
  input  wire logic [9:0]         conv_data,
  output logic                    irq,
  output logic                    result_ready_event,
  output logic                    analog_power,
  output logic                    sample_window,
  output logic                    sample_hold,
  output logic [4:0]              active_channel,
  output logic [1:0]              active_reference,
  output acs_pkg::acs_state_t     phase
);
  import acs_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Half the division factor for a divider code
  function automatic logic [7:0] half_of(input logic [2:0] code);
    half_of = 8'h01 << code;
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  logic        enable;             // Block enable
  logic        continuous_mode;    // Free-running restart
  logic        resolution_select;  // Stored for software only
  logic        event_start_enable; // Event may start
  logic [2:0]  clock_divider_select;
  logic        rr_irq_enable;      // Result ready interrupt enable
  logic        start_conversion_bit;
  logic [4:0]  input_channel_select; // Buffered channel
  logic [1:0]  reference_select;     // Buffered reference
  logic [3:0]  sample_delay;
  logic [3:0]  sample_length;
  logic [2:0]  accumulation_count;
  logic        result_ready_flag;
  logic [15:0] result;
  logic [15:0] acc_sum;            // Running accumulation
  logic [6:0]  samples_done;
  logic [7:0]  div_cnt;            // Prescaler counter
  logic [5:0]  cyc;                // Converter cycles into conversion
  logic        event_prev;         // Previous event level
  acs_state_t  state;

  // Bus access qualifiers: act only on the acknowledged edge
  logic bus_wr;
  logic bus_rd;
  assign bus_wr = avs_write && !avs_waitrequest;
  assign bus_rd = avs_read && !avs_waitrequest;

  logic       wr_cmd_start;      // Software start request
  logic       ev_start;          // Event rising edge start
  logic       tick;              // Converter clock rising edge
  logic [5:0] total_cyc;         // Conversion length
  logic [5:0] samp_cyc;          // Sample instant
  logic [6:0] samples_goal;      // Samples per trigger
  logic       final_tick;        // Last converter cycle
  logic       done_last;         // Triggered operation finished
  logic [2:0] acc_code;          // Clamped accumulation code
  logic [7:0] half;

  assign wr_cmd_start = bus_wr && avs_address == `ACS_OFF_CMD
                        && avs_writedata[`ACS_CMD_GO] && enable;
  assign ev_start     = start_event && !event_prev
                        && event_start_enable && enable;
  assign half         = half_of(clock_divider_select);
  // Rising edge of the divided clock at mid-period
  assign tick         = start_conversion_bit
                        && div_cnt == half - 8'h01;
  assign total_cyc    = `ACS_CONV_BASE + {2'h0, sample_delay}
                        + {2'h0, sample_length};
  assign samp_cyc     = `ACS_SAMP_BASE + {2'h0, sample_delay}
                        + {2'h0, sample_length};
  assign acc_code     = accumulation_count > `ACS_ACC_MAX ?
                        `ACS_ACC_MAX : accumulation_count;
  assign samples_goal = 7'h01 << acc_code;
  assign final_tick   = tick && state == ACS_CONV
                        && cyc == total_cyc - 6'h01;
  assign done_last    = final_tick
                        && samples_done == samples_goal - 7'h01;

  // ==========================================================
  // Bus handshake
  // ==========================================================
  // One wait cycle per access keeps read data registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data mux, sampled when the answer is offered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        `ACS_OFF_CTRL:   avs_readdata <= {24'h0, rr_irq_enable,
                           clock_divider_select, event_start_enable,
                           resolution_select, continuous_mode, enable};
        `ACS_OFF_CMD:    avs_readdata <= {31'h0,
                           start_conversion_bit};
        `ACS_OFF_SEL:    avs_readdata <= {22'h0, reference_select,
                           3'h0, input_channel_select};
        `ACS_OFF_SAMP:   avs_readdata <= {13'h0, accumulation_count,
                           4'h0, sample_length, 4'h0, sample_delay};
        `ACS_OFF_FLAGS:  avs_readdata <= {31'h0, result_ready_flag};
        `ACS_OFF_RESULT: avs_readdata <= {16'h0, result};
        `ACS_OFF_ACTIVE: avs_readdata <= {22'h0, active_reference,
                           3'h0, active_channel};
        default:         avs_readdata <= 32'h0; // Unmapped reads zero
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  // Settings assumed written before enable; no interlock here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable               <= 1'b0;
      continuous_mode      <= 1'b0;
      resolution_select    <= 1'b0;
      event_start_enable   <= 1'b0;
      clock_divider_select <= 3'h0;
      rr_irq_enable        <= 1'b0;
    end else if (bus_wr && avs_address == `ACS_OFF_CTRL) begin
      enable               <= avs_writedata[`ACS_CTRL_EN];
      continuous_mode      <= avs_writedata[`ACS_CTRL_CONT];
      resolution_select    <= avs_writedata[`ACS_CTRL_RES];
      event_start_enable   <= avs_writedata[`ACS_CTRL_EVST];
      clock_divider_select <=
        avs_writedata[`ACS_CTRL_PRE_HI:`ACS_CTRL_PRE_LO];
      rr_irq_enable        <= avs_writedata[`ACS_CTRL_RRIE];
    end
  end

  // Temporary selection buffer, free for software at any time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_channel_select <= 5'h0;
      reference_select     <= 2'h0;
    end else if (bus_wr && avs_address == `ACS_OFF_SEL) begin
      input_channel_select <= avs_writedata[`ACS_SEL_CH_HI:0];
      reference_select     <=
        avs_writedata[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO];
    end
  end

  // Sampling and accumulation settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_delay       <= 4'h0;
      sample_length      <= 4'h0;
      accumulation_count <= 3'h0;
    end else if (bus_wr && avs_address == `ACS_OFF_SAMP) begin
      sample_delay       <= avs_writedata[`ACS_SAMP_DLY_HI:0];
      sample_length      <=
        avs_writedata[`ACS_SAMP_LEN_HI:`ACS_SAMP_LEN_LO];
      accumulation_count <=
        avs_writedata[`ACS_SAMP_ACC_HI:`ACS_SAMP_ACC_LO];
    end
  end

  // ==========================================================
  // Start control
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_prev <= 1'b0;
    end else begin
      event_prev <= start_event;
    end
  end

  // Start bit: set by software or event, dropped on single-mode completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_conversion_bit <= 1'b0;
    end else if (!enable) begin
      start_conversion_bit <= 1'b0;
    end else if (wr_cmd_start || ev_start) begin
      start_conversion_bit <= 1'b1;
    end else if (done_last && !continuous_mode) begin
      start_conversion_bit <= 1'b0;
    end
  end

  // ==========================================================
  // Prescaler
  // ==========================================================
  // Held at zero while disabled or idle, fixing the start delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h0;
    end else if (!enable || !start_conversion_bit) begin
      div_cnt <= 8'h0;
    end else if (div_cnt == {half[6:0], 1'b0} - 8'h01) begin
      div_cnt <= 8'h0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ==========================================================
  // Conversion sequencer
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ACS_IDLE;
      cyc   <= 6'h0;
    end else if (!enable) begin
      state <= ACS_IDLE;
      cyc   <= 6'h0;
    end else begin
      unique case (state)
        ACS_IDLE: begin
          if (tick) begin
            state <= ACS_CONV;
            cyc   <= 6'h0;
          end
        end
        ACS_CONV: begin
          if (final_tick) begin
            cyc <= 6'h0;
            // Back-to-back only while the start bit stays high
            if (done_last && !continuous_mode) begin
              state <= ACS_IDLE;
            end
          end else if (tick) begin
            cyc <= cyc + 6'h01;
          end
        end
      endcase
    end
  end

  // Accumulation over a burst of samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_sum      <= 16'h0;
      samples_done <= 7'h0;
      result       <= 16'h0;
    end else if (!enable) begin
      acc_sum      <= 16'h0;
      samples_done <= 7'h0;
    end else if (done_last) begin
      result       <= acc_sum + {6'h0, conv_data};
      acc_sum      <= 16'h0;
      samples_done <= 7'h0;
    end else if (final_tick) begin
      acc_sum      <= acc_sum + {6'h0, conv_data};
      samples_done <= samples_done + 7'h01;
    end
  end

  // Active selection follows buffer while idle or in last cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_channel   <= 5'h0;
      active_reference <= 2'h0;
    end else if (enable && (state == ACS_IDLE || final_tick)) begin
      active_channel   <= input_channel_select;
      active_reference <= reference_select;
    end
  end

  // Sampling window and hold instant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_window <= 1'b0;
      sample_hold   <= 1'b0;
    end else begin
      sample_window <= state == ACS_CONV && cyc < samp_cyc;
      sample_hold   <= tick && state == ACS_CONV
                       && cyc == samp_cyc - 6'h01;
    end
  end

  // ==========================================================
  // Flag, interrupt and event
  // ==========================================================
  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ready_flag <= 1'b0;
    end else if (done_last) begin
      result_ready_flag <= 1'b1;
    end else if ((bus_rd && avs_address == `ACS_OFF_RESULT)
                 || (bus_wr && avs_address == `ACS_OFF_FLAGS
                     && avs_writedata[`ACS_FLAG_RR])) begin
      result_ready_flag <= 1'b0;
    end
  end

  // Registered request, one cycle behind its cause
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq                <= 1'b0;
      result_ready_event <= 1'b0;
      analog_power       <= 1'b0;
      phase              <= ACS_IDLE;
    end else begin
      irq                <= result_ready_flag && rr_irq_enable
                            && global_irq_enable;
      result_ready_event <= done_last && enable;
      analog_power       <= enable;
      phase              <= state;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_start_sets;
    @(posedge clk) disable iff (!rst_n)
    wr_cmd_start |=> start_conversion_bit;
  endproperty
  a_start_sets: assert property (p_start_sets)
    else $error("start write did not set start bit");

  property p_single_clear;
    @(posedge clk) disable iff (!rst_n)
    done_last && !continuous_mode && !wr_cmd_start && !ev_start
    |=> !start_conversion_bit ##1 state == ACS_IDLE;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single conversion did not end");

  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
    // Request follows the gates one cycle after the flag rises
    done_last |=> result_ready_flag
      ##1 irq == $past(rr_irq_enable && global_irq_enable);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag or request wrong after completion");

  property p_irq_cause;
    @(posedge clk) disable iff (!rst_n)
    irq |-> $past(result_ready_flag && rr_irq_enable);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request without enabled flag");

  property p_event_start;
    @(posedge clk) disable iff (!rst_n)
    ev_start |=> start_conversion_bit;
  endproperty
  a_event_start: assert property (p_event_start)
    else $error("event edge did not set start bit");

  property p_div_hold;
    @(posedge clk) disable iff (!rst_n)
    !enable || !start_conversion_bit |=> div_cnt == 8'h0;
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divider ran while held");

  property p_first_tick;
    @(posedge clk) disable iff (!rst_n)
    $rose(start_conversion_bit) && clock_divider_select == 3'h0
    |-> ##1 state == ACS_CONV;
  endproperty
  a_first_tick: assert property (p_first_tick)
    else $error("start delay wrong for smallest ratio");

  property p_lock;
    @(posedge clk) disable iff (!rst_n)
    state == ACS_CONV && !final_tick && enable
    |=> $stable(active_channel) && $stable(active_reference);
  endproperty
  a_lock: assert property (p_lock)
    else $error("selection changed mid conversion");

  property p_continue;
    @(posedge clk) disable iff (!rst_n)
    done_last && continuous_mode && enable
    |=> state == ACS_CONV && cyc == 6'h0;
  endproperty
  a_continue: assert property (p_continue)
    else $error("continuous mode did not restart");

  property p_event_pulse;
    @(posedge clk) disable iff (!rst_n)
    result_ready_event |=> !result_ready_event;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("result event longer than one cycle");
endmodule

// ===== tb/tb_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "acs_map.svh"
// ==================================================================
// Self-checking bench for the conversion sequencer
module tb_adc_conversion_sequencer;
  import acs_pkg::*;
  // Bench-driven inputs
  logic              clk;
  logic              rst_n;
  logic [5:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic              global_irq_enable;
  logic              start_event;
  logic [9:0]        conv_data;
  // Observed outputs
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  logic              result_ready_event;
  logic              analog_power;
  logic              sample_window;
  logic              sample_hold;
  logic [4:0]        active_channel;
  logic [1:0]        active_reference;
  acs_state_t        phase;
  // Scoreboard
  int                mismatches;
  int                check_count;
  int                win_cnt;
  int                hold_cnt;
  int                n;
  int                f;
  longint            t0;
  logic [31:0]       q;

  acs_sequencer dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .global_irq_enable(global_irq_enable), .start_event(start_event),
    .conv_data(conv_data), .irq(irq),
    .result_ready_event(result_ready_event),
    .analog_power(analog_power), .sample_window(sample_window),
    .sample_hold(sample_hold), .active_channel(active_channel),
    .active_reference(active_reference), .phase(phase)
  );

  // ================================================================
  // Clock, 4 ns period
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ================================================================
  // Reporting helpers
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One comparison, case equality so unknowns never match
  task chk(input string what, input logic [31:0] exp,
           input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // ================================================================
  // Avalon-MM master: hold request until waitrequest seen low
  task bus(input logic rd, input logic [5:0] a, input logic [31:0] wd);
    int k;
    // Extra edge keeps release and next raise in different steps
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= ~rd;
    avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 64);
    if (k >= 64) begin
      mismatches++;
      report_and_stop;
    end
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task rd(input logic [5:0] a, input logic [31:0] exp, input string nm);
    bus(1'h1, a, 32'h0);
    chk(nm, exp, q);
  endtask

  // Wait for the result event, tallying sampling activity meanwhile
  task wait_evt(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
      win_cnt  += sample_window;
      hold_cnt += sample_hold;
    end while (result_ready_event !== 1'h1 && k < 3000);
    if (k >= 3000) begin
      mismatches++;
      report_and_stop;
    end
  endtask

  // Control word: irq enable always set, divider select in [6:4]
  function logic [31:0] ctrl(input logic en, input logic cont,
                             input logic ev, input logic [2:0] dv);
    return {24'h0, 1'h1, dv, ev, 1'h0, cont, en};
  endfunction

  // ================================================================
  // Main sequence
  initial begin
    rst_n = 1'h0;
    avs_address = 6'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    global_irq_enable = 1'h0;
    start_event = 1'h0;
    conv_data = 10'h0;
    mismatches = 0;
    check_count = 0;
    win_cnt = 0;
    hold_cnt = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    // Reset values and an unmapped hole
    rd(`ACS_OFF_CTRL, 32'h0, "ctrl reset");
    rd(`ACS_OFF_FLAGS, 32'h0, "flags reset");
    rd(6'h1C, 32'h0, "unmapped read");
    chk("power off", 32'h0, {31'h0, analog_power});
    $display("Test reset done");

    // Selections are parked while disabled, then applied on enable
    bus(1'h0, `ACS_OFF_SEL, 32'h205);
    bus(1'h0, `ACS_OFF_SAMP, 32'h0);
    chk("chan disabled", 32'h0, {27'h0, active_channel});
    bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h1, 1'h0, 1'h0, 3'h0));
    rd(`ACS_OFF_ACTIVE, 32'h205, "active sel");
    chk("power on", 32'h1, {31'h0, analog_power});
    $display("Test selection buffering done");

    // Single conversions over three divider settings
    global_irq_enable <= 1'h1;
    for (int d = 0; d < 3; d++) begin
      f = 2 << d;
      conv_data <= 10'h2AB ^ 10'(d);
      bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h1, 1'h0, 1'h0, 3'(d)));
      bus(1'h0, `ACS_OFF_CMD, 32'h1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (phase !== ACS_CONV && n < 100);
      chk("start delay", 32'(f / 2 + 2), 32'(n));
      t0 = $time;
      bus(1'h0, `ACS_OFF_SEL, 32'(9 + d));
      chk("chan held", 32'(d == 0 ? 5 : 8 + d), 32'(active_channel));
      rd(`ACS_OFF_CMD, 32'h1, "start busy");
      wait_evt(n);
      n = int'(($time - t0) / 4);
      // Start seen two edges late, event one edge after completion
      chk("conv length", 32'(13 * f - 1), 32'(n));
      rd(`ACS_OFF_FLAGS, 32'h1, "flag set");
      chk("irq on", 32'h1, {31'h0, irq});
      rd(`ACS_OFF_CMD, 32'h0, "start clear");
      rd(`ACS_OFF_RESULT, 32'h2AB ^ 32'(d), "result");
      rd(`ACS_OFF_FLAGS, 32'h0, "flag read clr");
      chk("irq off", 32'h0, {31'h0, irq});
      chk("chan new", 32'(9 + d), 32'(active_channel));
    end
    $display("Test single conversion done");

    // Polling with the global enable off, write-one clear
    global_irq_enable <= 1'h0;
    bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h1, 1'h0, 1'h0, 3'h0));
    bus(1'h0, `ACS_OFF_CMD, 32'h1);
    wait_evt(n);
    rd(`ACS_OFF_FLAGS, 32'h1, "flag polled");
    chk("irq gated", 32'h0, {31'h0, irq});
    bus(1'h0, `ACS_OFF_FLAGS, 32'h1);
    rd(`ACS_OFF_FLAGS, 32'h0, "flag w1c");
    $display("Test polling done");

    // Start by event edge
    bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h1, 1'h0, 1'h1, 3'h0));
    start_event <= 1'h1;
    @(posedge clk);
    start_event <= 1'h0;
    rd(`ACS_OFF_CMD, 32'h1, "event start");
    wait_evt(n);
    rd(`ACS_OFF_CMD, 32'h0, "event done");
    $display("Test event start done");

    // Sampling window with delay 1, length 2, two samples summed
    conv_data <= 10'h155;
    bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h1, 1'h0, 1'h0, 3'h0));
    bus(1'h0, `ACS_OFF_SAMP, 32'h10201);
    bus(1'h0, `ACS_OFF_CMD, 32'h1);
    win_cnt = 0;
    hold_cnt = 0;
    wait_evt(n);
    chk("window", 32'(2 * 5 * 2), 32'(win_cnt));
    chk("hold pulses", 32'h2, 32'(hold_cnt));
    rd(`ACS_OFF_RESULT, 32'h2AA, "accum");
    n = 0;
    repeat (80) begin
      @(posedge clk);
      n += result_ready_event;
    end
    chk("extra events", 32'h0, 32'(n));
    $display("Test sampling done");

    // Continuous mode: fixed period, then stop by disable
    bus(1'h0, `ACS_OFF_SAMP, 32'h0);
    bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h1, 1'h1, 1'h0, 3'h0));
    bus(1'h0, `ACS_OFF_CMD, 32'h1);
    wait_evt(n);
    wait_evt(n);
    chk("period", 32'(13 * 2), 32'(n));
    rd(`ACS_OFF_CMD, 32'h1, "still running");
    bus(1'h0, `ACS_OFF_CTRL, ctrl(1'h0, 1'h1, 1'h0, 3'h0));
    rd(`ACS_OFF_CMD, 32'h0, "stopped");
    chk("idle", 32'h0, {31'h0, phase});
    chk("power down", 32'h0, {31'h0, analog_power});
    $display("Test continuous done");
    report_and_stop;
  end

  // ================================================================
  // Global watchdog against a hung sequence
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule
